//--- core/fast_counter_bank.sv
// fast counter bank with fast timer behind an AHB-Lite register slave
//
// Overview of operation
// - wide mode counts down only, preset zero
// - read select codes 0..3 pick counters
// - four independent 32-bit up/down pulse counters
// - counters count, compare, interrupt without software
// - read op copies live count to CPU register
// - hardware preset loads only from CPU preset
// - fast timer increments every 0.1 ms
// - write target 0 current, 1 preset
// - write op moves CPU register into hardware
// - count reaching preset sets pending next cycle, interrupt one cycle later if unmasked
// - write select 0..3 counters, 4 timer
// - writing zero current value clears count
// - match fires each time a step brings count to preset
`timescale 1ns/10ps
module fast_counter_bank #(
  parameter int unsigned NUM_CNT = fast_counter_pkg::NUM_HW
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [NUM_CNT-1:0] CNT_UP_IN,
  input wire logic [NUM_CNT-1:0] CNT_DN_IN,
  output logic [NUM_CNT:0] PENDING_OUT,
  output logic IRQ_OUT
);
  localparam int unsigned NUM_EVT = NUM_CNT + 1;
  localparam int unsigned TMR = NUM_CNT;
  localparam int unsigned CNT_W = fast_counter_pkg::CNT_W;

  if (NUM_CNT < 1 || NUM_CNT > fast_counter_pkg::NUM_HW) begin : g_bad_cnt
    $error("NUM_CNT must lie between 1 and 4");
  end

  // bus slave: address phase captured, reads take one wait state
  fast_counter_pkg::bus_req_t req_q;
  fast_counter_pkg::bus_req_t req_d;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  wire bus_acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire wr_fire = req_q.valid && req_q.write;
  wire rd_fire = req_q.valid && !req_q.write;
  wire hit_rd_ctrl = req_q.addr == fast_counter_pkg::OFF_RD_CTRL;
  wire hit_wr_cmd = req_q.addr == fast_counter_pkg::OFF_WR_CMD;
  wire hit_mode = req_q.addr == fast_counter_pkg::OFF_MODE;
  wire hit_status = req_q.addr == fast_counter_pkg::OFF_STATUS;
  wire hit_mask = req_q.addr == fast_counter_pkg::OFF_MASK;

  assign req_d.valid = bus_acc;
  assign req_d.write = HWRITE_IN;
  assign req_d.addr = HADDR_IN[fast_counter_pkg::ADDR_W-1:0];

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      req_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
    end else begin
      req_q <= req_d;
      hready_q <= !(bus_acc && !HWRITE_IN);
      hrdata_q <= rd_fire ? rd_mux : hrdata_q;
    end
  end

  // control registers
  fast_counter_pkg::read_op_t rd_ctrl_q;
  fast_counter_pkg::write_op_t wr_cmd_q;
  logic rd_en_prev_q;
  logic [NUM_CNT-1:0] mode_q;
  logic [NUM_EVT-1:0] status_q;
  logic [NUM_EVT-1:0] mask_q;
  logic irq_q;
  wire [NUM_EVT-1:0] match;
  wire [NUM_EVT-1:0] w1c = (wr_fire && hit_status) ? HWDATA_IN[NUM_EVT-1:0] : '0;
  wire [NUM_EVT-1:0] status_d = match | (status_q & ~w1c);
  wire wop_fire = wr_fire && hit_wr_cmd;
  wire [fast_counter_pkg::SEL_W-1:0] wop_sel =
    HWDATA_IN[fast_counter_pkg::WR_SEL_LSB +: fast_counter_pkg::SEL_W];
  wire wop_tgt = HWDATA_IN[fast_counter_pkg::WR_TGT_BIT];
  wire rd_trig = rd_ctrl_q.en && (!rd_ctrl_q.edge_mode || !rd_en_prev_q);

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_ctrl_q <= '0;
      wr_cmd_q <= '0;
      rd_en_prev_q <= 1'b0;
      mode_q <= '0;
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_fire && hit_rd_ctrl) begin
        rd_ctrl_q.en <= HWDATA_IN[fast_counter_pkg::RD_EN_BIT];
        rd_ctrl_q.edge_mode <= HWDATA_IN[fast_counter_pkg::RD_EDGE_BIT];
        rd_ctrl_q.sel <= HWDATA_IN[fast_counter_pkg::RD_SEL_LSB +: fast_counter_pkg::SEL_W];
      end
      if (wop_fire) begin
        wr_cmd_q.sel <= wop_sel;
        wr_cmd_q.target <= wop_tgt;
      end
      rd_en_prev_q <= rd_ctrl_q.en;
      mode_q <= (wr_fire && hit_mode) ? HWDATA_IN[NUM_CNT-1:0] : mode_q;
      mask_q <= (wr_fire && hit_mask) ? HWDATA_IN[NUM_EVT-1:0] : mask_q;
      status_q <= status_d;
      irq_q <= |(status_q & mask_q);
    end
  end

  // per channel logic: counters, then the timer in the last slot
  logic [CNT_W-1:0] count_q [NUM_EVT];
  logic [CNT_W-1:0] hw_pv_q [NUM_EVT];
  logic [CNT_W-1:0] cpu_cv_q [NUM_EVT];
  logic [CNT_W-1:0] cpu_pv_q [NUM_EVT];
  wire [CNT_W-1:0] count_d [NUM_EVT];
  wire [CNT_W-1:0] cv_view [NUM_EVT];
  wire [NUM_EVT-1:0] cv_load;
  wire [NUM_EVT-1:0] pv_load;
  wire [NUM_EVT-1:0] hit_cv;
  wire [NUM_EVT-1:0] hit_pv;
  wire [NUM_CNT-1:0] dn_edge;
  wire tick;

  for (genvar i = 0; i < NUM_EVT; i++) begin : g_chan
    localparam logic [fast_counter_pkg::SEL_W-1:0] CODE =
      (i == TMR) ? fast_counter_pkg::SEL_TIMER : fast_counter_pkg::SEL_W'(i);
    localparam logic [fast_counter_pkg::ADDR_W-1:0] CV_OFF =
      fast_counter_pkg::ADDR_W'(fast_counter_pkg::OFF_CV_BASE + i * fast_counter_pkg::OFF_STRIDE);
    localparam logic [fast_counter_pkg::ADDR_W-1:0] PV_OFF =
      fast_counter_pkg::ADDR_W'(fast_counter_pkg::OFF_PV_BASE + i * fast_counter_pkg::OFF_STRIDE);
    wire sel_hit = wop_fire && (wop_sel == CODE);
    wire rd_copy = (i != TMR) && rd_trig && (rd_ctrl_q.sel == CODE);
    wire step;
    wire [CNT_W-1:0] pv_eff;
    wire [CNT_W-1:0] stepped;

    assign hit_cv[i] = req_q.addr == CV_OFF;
    assign hit_pv[i] = req_q.addr == PV_OFF;
    assign cv_load[i] = sel_hit && (wop_tgt == fast_counter_pkg::TARGET_CV);
    assign pv_load[i] = sel_hit && (wop_tgt == fast_counter_pkg::TARGET_PV);
    // a load beats a pulse; a zero load clears the count
    assign count_d[i] = cv_load[i] ? cpu_cv_q[i] : (step ? stepped : count_q[i]);
    assign match[i] = step && !cv_load[i] && (stepped == pv_eff);
    assign cv_view[i] = (i == TMR) ? count_q[i] : cpu_cv_q[i];

    if (i == TMR) begin : g_timer
      assign step = tick;
      assign stepped = count_q[i] + fast_counter_pkg::CNT_ONE;
      assign pv_eff = hw_pv_q[i];
    end else begin : g_counter
      logic up_s1_q, up_s2_q, up_s3_q, dn_s1_q, dn_s2_q, dn_s3_q;
      wire wide = mode_q[i];
      wire up_edge = up_s2_q && !up_s3_q && !wide;
      assign dn_edge[i] = dn_s2_q && !dn_s3_q;
      assign step = up_edge ^ dn_edge[i];
      assign stepped = up_edge ? count_q[i] + fast_counter_pkg::CNT_ONE
                               : count_q[i] - fast_counter_pkg::CNT_ONE;
      assign pv_eff = wide ? fast_counter_pkg::WIDE_PRESET : hw_pv_q[i];
      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          {up_s1_q, up_s2_q, up_s3_q} <= 3'h0;
          {dn_s1_q, dn_s2_q, dn_s3_q} <= 3'h0;
        end else begin
          {up_s1_q, up_s2_q, up_s3_q} <= {CNT_UP_IN[i], up_s1_q, up_s2_q};
          {dn_s1_q, dn_s2_q, dn_s3_q} <= {CNT_DN_IN[i], dn_s1_q, dn_s2_q};
        end
      end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        count_q[i] <= fast_counter_pkg::CNT_RST;
        hw_pv_q[i] <= fast_counter_pkg::CNT_RST;
        cpu_cv_q[i] <= fast_counter_pkg::CNT_RST;
        cpu_pv_q[i] <= fast_counter_pkg::CNT_RST;
      end else begin
        count_q[i] <= count_d[i];
        hw_pv_q[i] <= pv_load[i] ? cpu_pv_q[i] : hw_pv_q[i];
        // copy takes the post-write value, so a write lands first
        if (rd_copy) begin
          cpu_cv_q[i] <= count_d[i];
        end else if (wr_fire && hit_cv[i]) begin
          cpu_cv_q[i] <= HWDATA_IN;
        end
        cpu_pv_q[i] <= (wr_fire && hit_pv[i]) ? HWDATA_IN : cpu_pv_q[i];
      end
    end
  end

  // fast timer tick
  logic [fast_counter_pkg::TICK_W-1:0] tick_q;
  assign tick = tick_q == fast_counter_pkg::TICK_W'(fast_counter_pkg::TICK_CYC - 1);
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + 1'b1;
    end
  end

  // read data selection
  always_comb begin
    rd_mux = '0;
    if (hit_rd_ctrl) begin
      rd_mux = 32'({rd_ctrl_q.sel, 2'b00, rd_ctrl_q.edge_mode, rd_ctrl_q.en});
    end
    if (hit_wr_cmd) begin
      rd_mux = 32'(wr_cmd_q);
    end
    if (hit_mode) begin
      rd_mux = 32'(mode_q);
    end
    if (hit_status) begin
      rd_mux = 32'(status_q);
    end
    if (hit_mask) begin
      rd_mux = 32'(mask_q);
    end
    for (int k = 0; k < NUM_EVT; k++) begin
      if (hit_cv[k]) begin
        rd_mux = cv_view[k];
      end
      if (hit_pv[k]) begin
        rd_mux = cpu_pv_q[k];
      end
    end
  end

  assign HRDATA_OUT = hrdata_q;
  assign HREADYOUT_OUT = hready_q;
  assign HRESP_OUT = 1'b0;
  assign PENDING_OUT = status_q;
  assign IRQ_OUT = irq_q;

  AST_WIDE_DOWN: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (mode_q[1] && !cv_load[1] && !dn_edge[1]) |=> count_q[1] == $past(count_q[1]))
    else $error("wide counter moved without a down pulse");
  AST_READ_SEL: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (rd_trig && rd_ctrl_q.sel == 3'h1) |=> cpu_cv_q[1] == $past(count_d[1]))
    else $error("read op did not copy counter one");
  AST_RD_EDGE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (rd_ctrl_q.en && rd_ctrl_q.edge_mode && rd_en_prev_q && rd_ctrl_q.sel == 3'h0 &&
     !(wr_fire && hit_cv[0])) |=> cpu_cv_q[0] == $past(cpu_cv_q[0]))
    else $error("edge read fired on a held enable");
  AST_PV_LOAD: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    pv_load[0] |=> hw_pv_q[0] == $past(cpu_pv_q[0]))
    else $error("hardware preset not taken from CPU preset");
  AST_TICK_GAP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    tick |=> !tick [*8])
    else $error("timer ticks too close together");
  AST_TMR_LOAD: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (wop_fire && wop_sel == 3'h4 && !wop_tgt) |=> count_q[TMR] == $past(cpu_cv_q[TMR]))
    else $error("code four did not load the timer");
  AST_CV_CLEAR: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (cv_load[0] && cpu_cv_q[0] == '0) |=> count_q[0] == '0)
    else $error("zero write did not clear the count");
  AST_MATCH_IRQ: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (match[0] && mask_q[0] && !(wr_fire && hit_mask)) |=> status_q[0] ##1 IRQ_OUT)
    else $error("match did not reach the interrupt");
  AST_PENDING: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (status_q[0] && !w1c[0]) |=> status_q[0])
    else $error("pending flag lost without acknowledge");
  AST_SAME_CYC: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (cv_load[0] && rd_trig && rd_ctrl_q.sel == 3'h0) |=> cpu_cv_q[0] == count_q[0])
    else $error("read beside a write missed the new value");
  AST_RD_WAIT: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (bus_acc && !HWRITE_IN) |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read wait state not exactly one cycle");
endmodule

//--- inc/fast_counter_pkg.sv
// constants and carrier types for the fast counter bank
package fast_counter_pkg;
  localparam int unsigned NUM_HW = 4;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned ADDR_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_RD_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_WR_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CV_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PV_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h3C;
  // field positions
  localparam int unsigned RD_EN_BIT = 0;
  localparam int unsigned RD_EDGE_BIT = 1;
  localparam int unsigned RD_SEL_LSB = 4;
  localparam int unsigned WR_SEL_LSB = 0;
  localparam int unsigned WR_TGT_BIT = 3;
  localparam logic [SEL_W-1:0] SEL_TIMER = 3'h4;
  localparam logic TARGET_CV = 1'b0;
  localparam logic TARGET_PV = 1'b1;
  // reset value, wide-mode preset and step of one
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] WIDE_PRESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  // fast timer base: 0.1 ms at a 50 ns clock
  localparam int unsigned TICK_NS = 100_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_CYC_RAW = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYC = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;
  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic edge_mode;
    logic en;
  } read_op_t;

  typedef struct packed {
    logic target;
    logic [SEL_W-1:0] sel;
  } write_op_t;
endpackage

//--- testbench/cpu_model.sv
// bus master model of the controller cpu issuing single word transfers
`timescale 1ns/10ps
module cpu_model (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out,
  output logic got_out,
  output logic [31:0] data_out,
  output logic hang_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0000_0000;
    got_out = 1'b0;
    data_out = 32'h0000_0000;
    hang_out = 1'b0;
  end
  // address phase held until hready, then data phase until hready
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    hsel_out <= 1'b1;
    haddr_out <= {24'h00_0000, addr};
    hwrite_out <= wr;
    htrans_out <= 2'h2;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 64);
    hang_out <= (n >= 64);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= wdata;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 64);
    data_out <= hrdata_in;
    got_out <= !wr;
    hang_out <= (n >= 64);
  endtask
  always @(posedge clk_in) begin
    if (got_out) begin
      got_out <= 1'b0;
    end
  end
endmodule

//--- testbench/tb.sv
// self-checking bench for the fast counter bank
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel, hwrite, hready, hresp, got, hang, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdata, v;
  logic [3:0] up = 4'h0;
  logic [3:0] dn = 4'h0;
  logic [4:0] pend;
  logic [31:0] expq[$];
  int num_errors = 0;
  int checks = 0;
  int seed = 33;
  always #25 clk = ~clk;
  fast_counter_bank i_dut (.CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .CNT_UP_IN(up), .CNT_DN_IN(dn), .PENDING_OUT(pend), .IRQ_OUT(irq));
  cpu_model i_cpu (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata), .got_out(got), .data_out(rdata), .hang_out(hang));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // oldest note against each completed read
  always @(posedge clk) begin
    if (got === 1'b1) begin
      cmp("read data", (expq.size() > 0) ? expq.pop_front() : ~rdata, rdata);
    end
  end
  always @(posedge hang) begin
    num_errors++;
    conclude();
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cpu.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    i_cpu.xfer(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [7:0] cva(input int ch);
    return fast_counter_pkg::OFF_CV_BASE + 8'(ch) * fast_counter_pkg::OFF_STRIDE;
  endfunction
  task automatic load(input int ch, input logic tgt, input logic [31:0] val);
    wr(cva(ch) + (tgt ? 8'h04 : 8'h00), val);
    wr(fast_counter_pkg::OFF_WR_CMD, {28'h000_0000, tgt, 3'(ch)});
  endtask
  task automatic readop(input int ch, input logic edg);
    wr(fast_counter_pkg::OFF_RD_CTRL, {25'h000_0000, 3'(ch), 2'b00, edg, 1'b1});
  endtask
  task automatic pulse(input int ch, input logic upw, input int cnt);
    repeat (cnt) begin
      up[ch] <= upw;
      dn[ch] <= !upw;
      repeat (2) @(posedge clk);
      up[ch] <= 1'b0;
      dn[ch] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    for (int ch = 0; ch < 4; ch++) begin
      v = $random(seed);
      load(ch, fast_counter_pkg::TARGET_CV, v);
      pulse(ch, 1'b1, 3);
      pulse(ch, 1'b0, 1);
      readop(ch, 1'b0);
      rd(cva(ch), v + 32'h0000_0002);
      wr(fast_counter_pkg::OFF_RD_CTRL, 32'h0000_0000);
      readop(ch, 1'b1);
      pulse(ch, 1'b1, 1);
      wr(fast_counter_pkg::OFF_RD_CTRL, 32'h0000_0041);
      rd(cva(ch), v + 32'h0000_0002);
    end
    wr(fast_counter_pkg::OFF_MASK, 32'h0000_0001);
    load(0, fast_counter_pkg::TARGET_PV, 32'h0000_0002);
    load(0, fast_counter_pkg::TARGET_CV, 32'h0000_0000);
    readop(0, 1'b0);
    rd(cva(0), 32'h0000_0000);
    wr(fast_counter_pkg::OFF_WR_CMD, 32'h0000_0000);
    pulse(0, 1'b1, 2);
    cmp("pending", 32'h0000_0001, {27'h000_0000, pend});
    cmp("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(fast_counter_pkg::OFF_STATUS, 32'h0000_0001);
    rd(fast_counter_pkg::OFF_STATUS, 32'h0000_0000);
    cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wr(fast_counter_pkg::OFF_MASK, 32'h0000_0000);
    pulse(0, 1'b1, 1);
    pulse(0, 1'b0, 1);
    rd(fast_counter_pkg::OFF_STATUS, 32'h0000_0001);
    cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wr(fast_counter_pkg::OFF_STATUS, 32'h0000_0001);
    wr(fast_counter_pkg::OFF_MODE, 32'h0000_0002);
    load(1, fast_counter_pkg::TARGET_PV, 32'h0000_0000);
    load(1, fast_counter_pkg::TARGET_CV, 32'h0000_0002);
    pulse(1, 1'b1, 1);
    pulse(1, 1'b0, 2);
    rd(fast_counter_pkg::OFF_STATUS, 32'h0000_0002);
    load(4, fast_counter_pkg::TARGET_PV, 32'h0000_0001);
    load(4, fast_counter_pkg::TARGET_CV, 32'h0000_0000);
    repeat (fast_counter_pkg::TICK_CYC + 10) @(posedge clk);
    rd(fast_counter_pkg::OFF_STATUS, 32'h0000_0012);
    cmp("pending", 32'h0000_0012, {27'h000_0000, pend});
    rd(cva(4), 32'h0000_0001);
    cmp("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
